//--- rtl/mode_reg_pkg.sv
// constants and types for the mode-register programming block
package mode_reg_pkg;
  // ==========================================================================
  // register widths and reset values
  localparam int ADDR_W = 15;
  localparam logic [14:0] MAIN_REG_RESET = 15'h0000;
  localparam logic [14:0] EXT1_REG_RESET = 15'h0000;
  // ==========================================================================
  // target register select on the bank bits
  localparam logic [2:0] SEL_MAIN = 3'h0;
  localparam logic [2:0] SEL_EXT1 = 3'h1;
  localparam logic [2:0] SEL_EXT2 = 3'h2;
  localparam logic [2:0] SEL_EXT3 = 3'h3;
  // ==========================================================================
  // main register field positions
  localparam int BL_LSB = 0;
  localparam int BT_BIT = 3;
  localparam int CL_LSB = 4;
  localparam int TM_BIT = 7;
  localparam int DLLRST_BIT = 8;
  localparam int WR_LSB = 9;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [3:0] BEATS_4 = 4'h4;
  localparam logic [3:0] BEATS_8 = 4'h8;
  // ==========================================================================
  // extended register 1 field positions
  localparam int DLLDIS_BIT = 0;
  localparam int DRV_BIT = 1;
  localparam int RTT_LO_BIT = 2;
  localparam int AL_LSB = 3;
  localparam int RTT_HI_BIT = 6;
  localparam int CAL_LSB = 7;
  localparam int DQSN_BIT = 10;
  localparam int RDQS_BIT = 11;
  localparam int QOFF_BIT = 12;
  // ==========================================================================
  // timing: delay-locked loop settle time, in clocks
  localparam logic [7:0] DLL_LOCK_CYCLES = 8'hC8;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  // ==========================================================================
  // enumerations
  typedef enum logic [2:0] {
    CAL_EXIT = 3'b000,
    CAL_DRIVE_HIGH = 3'b001,
    CAL_DRIVE_LOW = 3'b010,
    CAL_ADJUST = 3'b100,
    CAL_DEFAULT = 3'b111
  } cal_mode_t;
  typedef enum logic [1:0] {
    DLL_OFF = 2'b00,
    DLL_LOCKING = 2'b01,
    DLL_LOCKED = 2'b10
  } dll_state_t;
endpackage : mode_reg_pkg

//--- rtl/mode_reg_prog.sv
// mode-register command decode, field storage and delay-locked loop control
`timescale 1ns/1ps
module mode_reg_prog
  import mode_reg_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CKE_I,
  input wire logic CS_N_I,
  input wire logic RAS_N_I,
  input wire logic CAS_N_I,
  input wire logic WE_N_I,
  input wire logic [2:0] BA_I,
  input wire logic [14:0] ADDR_I,
  output logic [14:0] MAIN_REG_O,
  output logic [14:0] EXT1_REG_O,
  output logic MAIN_VALID_O,
  output logic EXT1_VALID_O,
  output logic EXT2_WRITE_O,
  output logic EXT3_WRITE_O,
  output logic [3:0] BURST_BEATS_O,
  output logic BURST_RESERVED_O,
  output logic BURST_INTERLEAVE_O,
  output logic [2:0] CAS_LATENCY_O,
  output logic TEST_MODE_O,
  output logic [2:0] WRITE_RECOVERY_O,
  output logic DLL_ENABLE_O,
  output logic DLL_RESET_O,
  output logic DLL_LOCKED_O,
  output logic SELF_REFRESH_O,
  output logic DRIVE_REDUCED_O,
  output logic [1:0] TERM_SEL_O,
  output logic [2:0] ADD_LATENCY_O,
  output logic STROBE_N_DISABLE_O,
  output logic READ_STROBE_EN_O,
  output logic OUTPUT_DISABLE_O,
  output cal_mode_t CAL_MODE_O
);

  // ==========================================================================
  // command decode
  // command pins are sampled on the device clock, so no synchroniser is used
  function automatic logic is_write_cmd(input logic cs_n, input logic ras_n, input logic cas_n,
                                        input logic we_n);
    is_write_cmd = !cs_n && !ras_n && !cas_n && !we_n;
  endfunction : is_write_cmd

  logic write_cmd;
  logic main_wr;
  logic ext1_wr;
  logic refresh_cmd;
  assign write_cmd = is_write_cmd(CS_N_I, RAS_N_I, CAS_N_I, WE_N_I) && CKE_I;
  assign main_wr = write_cmd && (BA_I == SEL_MAIN);
  assign ext1_wr = write_cmd && (BA_I == SEL_EXT1);
  assign refresh_cmd = !CS_N_I && !RAS_N_I && !CAS_N_I && WE_N_I;

  // ==========================================================================
  // register storage
  // writes only change mode state; there is no path to the cell array
  logic [14:0] main_reg, main_next;
  logic [14:0] ext1_reg, ext1_next;
  logic main_valid_reg, main_valid_next;
  logic ext1_valid_reg, ext1_valid_next;
  logic ext2_wr_reg, ext2_wr_next;
  logic ext3_wr_reg, ext3_wr_next;

  always_comb begin
    main_next = main_reg;
    ext1_next = ext1_reg;
    main_valid_next = main_valid_reg;
    ext1_valid_next = ext1_valid_reg;
    if (main_wr) begin
      main_next = ADDR_I;
      main_valid_next = 1'b1;
    end
    if (ext1_wr) begin
      ext1_next = ADDR_I;
      ext1_valid_next = 1'b1;
    end
    ext2_wr_next = write_cmd && (BA_I == SEL_EXT2);
    ext3_wr_next = write_cmd && (BA_I == SEL_EXT3);
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      main_reg <= MAIN_REG_RESET;
      ext1_reg <= EXT1_REG_RESET;
      main_valid_reg <= 1'b0;
      ext1_valid_reg <= 1'b0;
      ext2_wr_reg <= 1'b0;
      ext3_wr_reg <= 1'b0;
    end else begin
      main_reg <= main_next;
      ext1_reg <= ext1_next;
      main_valid_reg <= main_valid_next;
      ext1_valid_reg <= ext1_valid_next;
      ext2_wr_reg <= ext2_wr_next;
      ext3_wr_reg <= ext3_wr_next;
    end
  end

  // ==========================================================================
  // field decode
  logic [2:0] bl_code;
  assign bl_code = main_reg[BL_LSB+:3];
  always_comb begin
    case (bl_code)
      BL_CODE_4: BURST_BEATS_O = BEATS_4;
      BL_CODE_8: BURST_BEATS_O = BEATS_8;
      default: BURST_BEATS_O = BEATS_4;
    endcase
  end
  assign BURST_RESERVED_O = (bl_code != BL_CODE_4) && (bl_code != BL_CODE_8);
  assign BURST_INTERLEAVE_O = main_reg[BT_BIT];
  // latency is a whole-clock code; there is no half-clock bit to carry
  assign CAS_LATENCY_O = main_reg[CL_LSB+:3];
  assign TEST_MODE_O = main_reg[TM_BIT];
  assign WRITE_RECOVERY_O = main_reg[WR_LSB+:3];
  assign DRIVE_REDUCED_O = ext1_reg[DRV_BIT];
  assign TERM_SEL_O = {ext1_reg[RTT_HI_BIT], ext1_reg[RTT_LO_BIT]};
  assign ADD_LATENCY_O = ext1_reg[AL_LSB+:3];
  assign STROBE_N_DISABLE_O = ext1_reg[DQSN_BIT];
  assign READ_STROBE_EN_O = ext1_reg[RDQS_BIT];
  assign OUTPUT_DISABLE_O = ext1_reg[QOFF_BIT];
  always_comb begin
    case (ext1_reg[CAL_LSB+:3])
      3'h0: CAL_MODE_O = CAL_EXIT;
      3'h1: CAL_MODE_O = CAL_DRIVE_HIGH;
      3'h2: CAL_MODE_O = CAL_DRIVE_LOW;
      3'h4: CAL_MODE_O = CAL_ADJUST;
      3'h7: CAL_MODE_O = CAL_DEFAULT;
      default: CAL_MODE_O = CAL_EXIT;
    endcase
  end
  assign MAIN_REG_O = main_reg;
  assign EXT1_REG_O = ext1_reg;
  assign MAIN_VALID_O = main_valid_reg;
  assign EXT1_VALID_O = ext1_valid_reg;
  assign EXT2_WRITE_O = ext2_wr_reg;
  assign EXT3_WRITE_O = ext3_wr_reg;

  // ==========================================================================
  // self refresh and delay-locked loop control
  logic cke_reg, cke_next;
  logic sr_reg, sr_next;
  logic dll_rst_reg, dll_rst_next;
  dll_state_t dll_state_reg, dll_state_next;
  logic [7:0] lock_cnt_reg, lock_cnt_next;
  logic sr_entry;
  logic sr_exit;
  logic dll_want;

  assign sr_entry = !sr_reg && cke_reg && !CKE_I && refresh_cmd;
  assign sr_exit = sr_reg && CKE_I;
  // a fresh enable bit takes effect on the same edge that loads the register
  assign dll_want = ext1_next[DLLDIS_BIT] == 1'b0;

  always_comb begin
    cke_next = CKE_I;
    sr_next = sr_reg;
    if (sr_entry) begin
      sr_next = 1'b1;
    end else if (sr_exit) begin
      sr_next = 1'b0;
    end
    // exit from self refresh restarts the loop as if reset
    dll_rst_next = (main_wr && ADDR_I[DLLRST_BIT]) || sr_exit;
    dll_state_next = dll_state_reg;
    lock_cnt_next = lock_cnt_reg;
    if (!dll_want || sr_next) begin
      dll_state_next = DLL_OFF;
      lock_cnt_next = CNT_ZERO;
    end else if (dll_rst_next || dll_state_reg == DLL_OFF) begin
      dll_state_next = DLL_LOCKING;
      lock_cnt_next = CNT_ZERO;
    end else begin
      case (dll_state_reg)
        DLL_LOCKING: begin
          lock_cnt_next = lock_cnt_reg + 8'h01;
          if (lock_cnt_reg == DLL_LOCK_CYCLES - 8'h01) begin
            dll_state_next = DLL_LOCKED;
          end
        end
        DLL_LOCKED: dll_state_next = DLL_LOCKED;
        default: dll_state_next = DLL_OFF;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cke_reg <= 1'b0;
      sr_reg <= 1'b0;
      dll_rst_reg <= 1'b0;
      dll_state_reg <= DLL_OFF;
      lock_cnt_reg <= CNT_ZERO;
    end else begin
      cke_reg <= cke_next;
      sr_reg <= sr_next;
      dll_rst_reg <= dll_rst_next;
      dll_state_reg <= dll_state_next;
      lock_cnt_reg <= lock_cnt_next;
    end
  end

  assign DLL_ENABLE_O = dll_state_reg != DLL_OFF;
  assign DLL_RESET_O = dll_rst_reg;
  assign DLL_LOCKED_O = dll_state_reg == DLL_LOCKED;
  assign SELF_REFRESH_O = sr_reg;

  // ==========================================================================
  // checks
  property p_main_load;
    @(posedge CLK_I) disable iff (!RST_N_I)
    main_wr |=> (MAIN_REG_O == $past(ADDR_I)) && MAIN_VALID_O;
  endproperty
  a_main_load: assert property (p_main_load) else $error("main register not loaded");

  property p_ext1_load;
    @(posedge CLK_I) disable iff (!RST_N_I)
    ext1_wr |=> EXT1_REG_O == $past(ADDR_I);
  endproperty
  a_ext1_load: assert property (p_ext1_load) else $error("ext1 register not loaded");

  property p_sel;
    @(posedge CLK_I) disable iff (!RST_N_I)
    (write_cmd && BA_I == SEL_EXT2) |=> EXT2_WRITE_O && !EXT3_WRITE_O && $stable(MAIN_REG_O);
  endproperty
  a_sel: assert property (p_sel) else $error("wrong target register");

  property p_burst;
    @(posedge CLK_I) disable iff (!RST_N_I)
    (MAIN_REG_O[2:0] == BL_CODE_8) |-> (BURST_BEATS_O == BEATS_8) && !BURST_RESERVED_O;
  endproperty
  a_burst: assert property (p_burst) else $error("burst length decode wrong");

  property p_dll_reset;
    @(posedge CLK_I) disable iff (!RST_N_I)
    (main_wr && ADDR_I[DLLRST_BIT]) |=> DLL_RESET_O ##1 !DLL_RESET_O [*1];
  endproperty
  a_dll_reset: assert property (p_dll_reset) else $error("loop reset not pulsed");

  property p_dll_disable;
    @(posedge CLK_I) disable iff (!RST_N_I)
    (ext1_wr && ADDR_I[DLLDIS_BIT]) |=> !DLL_ENABLE_O;
  endproperty
  a_dll_disable: assert property (p_dll_disable) else $error("loop still enabled");

  property p_sr_entry;
    @(posedge CLK_I) disable iff (!RST_N_I)
    sr_entry |=> !DLL_ENABLE_O && SELF_REFRESH_O;
  endproperty
  a_sr_entry: assert property (p_sr_entry) else $error("loop on in self refresh");

  property p_lock_wait;
    @(posedge CLK_I) disable iff (!RST_N_I)
    $rose(DLL_LOCKED_O) |-> $past(lock_cnt_reg) == DLL_LOCK_CYCLES - 8'h01;
  endproperty
  a_lock_wait: assert property (p_lock_wait) else $error("lock reported early");

  property p_term;
    @(posedge CLK_I) disable iff (!RST_N_I)
    ext1_wr |=> TERM_SEL_O == {$past(ADDR_I[6]), $past(ADDR_I[2])};
  endproperty
  a_term: assert property (p_term) else $error("termination select wrong");

endmodule : mode_reg_prog

//--- testbench/ctrl_model.sv
// controller-side model issuing mode-register and self refresh commands
`timescale 1ns/1ps
module ctrl_model (
  input wire logic clk_i,
  output logic cke_o,
  output logic cs_n_o,
  output logic ras_n_o,
  output logic cas_n_o,
  output logic we_n_o,
  output logic [2:0] ba_o,
  output logic [14:0] addr_o
);
  // ==========================================================================
  // command spacing, a plain default for mode_cmd_cycle_time
  localparam int CMD_GAP = 2;
  initial begin
    cke_o = 1'b0;
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hF;
    ba_o = 3'h0;
    addr_o = 15'h0000;
  end
  // ==========================================================================
  // caller sits just after a falling edge; returns just after the falling edge that follows the take
  // the bench programs the main register first and relies on the extended register's reset value to enable the loop
  task automatic issue(input logic [2:0] ba, input logic [14:0] a, input logic cke);
    repeat (CMD_GAP - 1) @(negedge clk_i);
    cke_o = cke;
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'h0;
    ba_o = ba;
    addr_o = (ba == 3'h0) ? (a & 15'h7F7F) : a;
    @(negedge clk_i);
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hF;
    // released lines change so a stale value never looks valid
    addr_o = ~addr_o;
    ba_o = ~ba_o;
  endtask : issue
  task automatic sr_enter;
    @(negedge clk_i);
    cke_o = 1'b0;
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'h1;
    @(negedge clk_i);
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hF;
  endtask : sr_enter
  task automatic sr_exit;
    @(negedge clk_i);
    cke_o = 1'b1;
    @(negedge clk_i);
  endtask : sr_exit
endmodule : ctrl_model

//--- testbench/tb_mode_reg_prog.sv
// self-checking bench for the mode-register programming block
`timescale 1ns/1ps
module tb_mode_reg_prog;
  import mode_reg_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cke, cs_n, ras_n, cas_n, we_n;
  logic [2:0] ba, cas_lat, wr_rec, al;
  logic [14:0] addr, main_reg, ext1_reg;
  logic main_valid, ext1_valid, ext2_wr, ext3_wr, reserved, interleave, test_mode;
  logic dll_en, dll_rst, locked, sr, drive, sn, rdqs, qoff;
  logic [3:0] beats;
  logic [1:0] term;
  cal_mode_t cal;
  logic [2:0] cal_tab [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7, 3'h3};
  logic [14:0] d;
  int n_mismatch = 0;
  int cmp_count = 0;
  always #10 clk = ~clk;
  ctrl_model ctrl_model_inst (.clk_i(clk), .cke_o(cke), .cs_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n),
    .we_n_o(we_n), .ba_o(ba), .addr_o(addr));
  mode_reg_prog mode_reg_prog_inst (.CLK_I(clk), .RST_N_I(rst_n), .CKE_I(cke), .CS_N_I(cs_n),
    .RAS_N_I(ras_n), .CAS_N_I(cas_n), .WE_N_I(we_n), .BA_I(ba), .ADDR_I(addr), .MAIN_REG_O(main_reg),
    .EXT1_REG_O(ext1_reg), .MAIN_VALID_O(main_valid), .EXT1_VALID_O(ext1_valid), .EXT2_WRITE_O(ext2_wr),
    .EXT3_WRITE_O(ext3_wr), .BURST_BEATS_O(beats), .BURST_RESERVED_O(reserved),
    .BURST_INTERLEAVE_O(interleave), .CAS_LATENCY_O(cas_lat), .TEST_MODE_O(test_mode),
    .WRITE_RECOVERY_O(wr_rec), .DLL_ENABLE_O(dll_en), .DLL_RESET_O(dll_rst), .DLL_LOCKED_O(locked),
    .SELF_REFRESH_O(sr), .DRIVE_REDUCED_O(drive), .TERM_SEL_O(term), .ADD_LATENCY_O(al),
    .STROBE_N_DISABLE_O(sn), .READ_STROBE_EN_O(rdqs), .OUTPUT_DISABLE_O(qoff), .CAL_MODE_O(cal));
  // ==========================================================================
  // compare and closing tasks
  task automatic chk(input logic [14:0] got, input logic [14:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  // called in the cycle the loop restarts; lock shows 200 edges after the restarting edge
  task automatic lock_wait;
    chk(15'({dll_en, locked}), 15'h0002);
    repeat (199) @(negedge clk);
    chk(15'(locked), 15'h0000);
    @(negedge clk);
    chk(15'(locked), 15'h0001);
  endtask : lock_wait
  task automatic main_chk(input logic [14:0] v, input logic [3:0] bt, input logic rsv);
    chk(main_reg, v);
    chk(15'({main_valid, beats, reserved}), 15'({1'b1, bt, rsv}));
    chk(15'({interleave, cas_lat, test_mode}), 15'({v[3], v[6:4], v[7]}));
    chk(15'({wr_rec, dll_rst}), 15'({v[11:9], v[8]}));
  endtask : main_chk
  // ==========================================================================
  // tests
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    chk(15'({main_valid, ext1_valid, locked, sr, reserved, beats}), 15'h0014);
    $display("reset test done");
    // a 55 ns recovery time over the 20 ns clock rounds up to a recovery field of 3
    ctrl_model_inst.issue(3'h0, 15'h075A, 1'b1);
    main_chk(15'h075A, 4'h4, 1'b0);
    lock_wait();
    for (int i = 0; i < 8; i++) begin
      d = 15'h0A30 | 15'(i);
      ctrl_model_inst.issue(3'h0, d, 1'b1);
      main_chk(d, (i == 3) ? 4'h8 : 4'h4, (i != 2 && i != 3));
    end
    chk(15'(locked), 15'h0001);
    $display("main register test done");
    ctrl_model_inst.issue(3'h1, 15'h0001, 1'b1);
    chk(15'({ext1_valid, dll_en, locked}), 15'h0004);
    for (int k = 0; k < 6; k++) begin
      d = {2'b00, ~k[0], k[1], k[0], cal_tab[k], k[1], k[2:0], k[0], k[0], 1'b0};
      ctrl_model_inst.issue(3'h1, d, 1'b1);
      chk(ext1_reg, d);
      chk(15'({drive, term, al, sn}), 15'({k[0], k[1:0], k[2:0], k[0]}));
      chk(15'({rdqs, qoff, cal}), 15'({k[1], ~k[0], (k == 5) ? 3'h0 : cal_tab[k]}));
      if (k == 0) lock_wait();
    end
    $display("extended register test done");
    ctrl_model_inst.issue(3'h2, 15'h0000, 1'b1);
    chk(15'({ext2_wr, ext3_wr}), 15'h0002);
    @(negedge clk);
    chk(15'(ext2_wr), 15'h0000);
    ctrl_model_inst.issue(3'h3, 15'h0000, 1'b1);
    chk(15'({ext2_wr, ext3_wr}), 15'h0001);
    ctrl_model_inst.issue(3'h4, 15'h7FFF, 1'b1);
    chk(15'({ext2_wr, ext3_wr, dll_rst}), 15'h0000);
    chk(main_reg, 15'h0A37);
    ctrl_model_inst.issue(3'h0, 15'h0163, 1'b0);
    chk(15'({dll_rst, 11'h000, locked}), 15'h0001);
    chk(main_reg, 15'h0A37);
    ctrl_model_inst.issue(3'h1, 15'h0000, 1'b1);
    chk(ext1_reg, 15'h0000);
    $display("select and refusal test done");
    ctrl_model_inst.sr_enter();
    chk(15'({sr, dll_en, locked}), 15'h0004);
    repeat (5) @(negedge clk);
    ctrl_model_inst.sr_exit();
    chk(15'({sr, dll_rst}), 15'h0001);
    lock_wait();
    $display("self refresh test done");
    wrap_up();
  end
  // the tests need under 2000 cycles; the limit leaves wide margin
  initial begin
    #(5000 * 20);
    n_mismatch++;
    wrap_up();
  end
endmodule : tb_mode_reg_prog
